// file: sfmr_read_ctl.sv
`timescale 1ns/1ns
// How it works
// - 0Bh takes three address bytes, or four when extended address is set.
// - 0Ch always takes four address bytes.
// - Latency fast read waits zero or eight dummy cycles per latency code.
// - Output is undriven during dummy cycles, then array data on lane one.
// - Any start byte, address increments per byte, wraps to zero while selected.
// - 3Bh follows extended setting; 3Ch always takes four address bytes.
// - Two lane output read returns two bits per falling edge on lanes zero, one.
// - Two lane output read waits zero or eight dummy cycles, input ignored.
// - 6Bh follows extended setting; 6Ch always takes four address bytes.
// - Four lane output read returns one nibble per falling edge after dummies.
// - Four lane reads work only when configuration bit 1 is set.
// - BBh follows extended setting; BCh always takes four address bytes.
// - Dual I/O address arrives two bits per rising edge on lanes zero, one.
// - Dual I/O read: opcode, address, four mode cycles, latency, data.
// - Mode upper nibble Ah makes the next select start directly with address.
// - Only mode bits 7-4 decide continuous mode; bits 3-0 ignored.
// - Other mode nibble leaves continuous mode at next chip select rise.
// - Short select of eight clocks or fewer without valid sequence leaves mode.
// - Dual I/O dummy count comes from latency code of configuration one.
// - Every read outside continuous mode starts with opcode, one bit per rising edge, then address.
// - Raising chip select during data ends the read.
// - Address bits above 23 are ignored.
// - Dummies count falling to falling; zero dummies means data at that edge.
module sfmr_read_ctl
   import sfmr_pkg::*;
#(
   parameter int ARRAY_AW = 8
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Serial pins
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic [3:0] DQ_I,
   output logic [3:0] DQ_O,
   output logic [3:0] DQ_OE,
   // Configuration
   input wire logic EXT_ADDR,
   input wire logic [7:0] CFG_ONE,
   // Array load port
   input wire logic LOAD_EN,
   input wire logic [ARRAY_AW-1:0] LOAD_ADDR,
   input wire logic [7:0] LOAD_DATA,
   // Status
   output logic CONT_MODE,
   output logic BUSY
);
   import sfmr_pkg::*;

   typedef enum {ST_IDLE, ST_OPC, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE} sfmr_state_e;

   initial begin
      if (ARRAY_AW < 1 || ARRAY_AW > ADDR_W) $error("sfmr_read_ctl: ARRAY_AW out of range");
   end

   logic rise, fall, cs_start, cs_end;
   logic [7:0] rd_data;
   sfmr_state_e st_reg, st_next;
   logic [31:0] sh_reg, sh_next;
   logic [5:0] cnt_reg, cnt_next;
   logic [5:0] alen_reg, alen_next;
   logic [3:0] dum_reg, dum_next;
   sfmr_width_e w_reg, w_next;
   logic dio_reg, dio_next;
   logic cont_reg, cont_next;
   logic keep_reg, keep_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [7:0] byte_reg, byte_next;
   logic [2:0] bit_reg, bit_next;
   logic [3:0] dq_reg, dq_next;
   logic [3:0] oe_reg, oe_next;
   logic busy_reg, busy_next;
   logic [3:0] lat;
   logic [5:0] abits;
   logic [ADDR_W-1:0] new_addr;

   sfmr_edge u_edge (
      .clk(CLK),
      .rst_n(RST_N),
      .sck(SCK),
      .cs_n(CS_N),
      .rise(rise),
      .fall(fall),
      .cs_start(cs_start),
      .cs_end(cs_end)
   );

   sfmr_array #(.AW(ARRAY_AW)) u_array (
      .clk(CLK),
      .rd_addr(addr_reg[ARRAY_AW-1:0]),
      .rd_data(rd_data),
      .wr_en(LOAD_EN),
      .wr_addr(LOAD_ADDR),
      .wr_data(LOAD_DATA)
   );

   // Dummy count from latency code
   assign lat = (CFG_ONE[CFG_LC_LSB+1:CFG_LC_LSB] == LC_NO_DUMMY) ? DUMMY_NONE : DUMMY_LONG;
   // Addresses are cut to 24 bits, so a 4-byte address keeps only its low bytes
   assign new_addr = sh_reg[ADDR_W-1:0];

   // Command sequencer: decode, header shift, dummies and data shift
   always_comb begin
      st_next = st_reg;
      sh_next = sh_reg;
      cnt_next = cnt_reg;
      alen_next = alen_reg;
      dum_next = dum_reg;
      w_next = w_reg;
      dio_next = dio_reg;
      cont_next = cont_reg;
      keep_next = keep_reg;
      addr_next = addr_reg;
      byte_next = byte_reg;
      bit_next = bit_reg;
      dq_next = dq_reg;
      oe_next = oe_reg;
      busy_next = busy_reg;
      abits = dio_reg ? {1'b0, alen_reg[5:1]} : alen_reg;
      if (cs_end) begin
         // Select high ends any phase; continuous mode decided from last mode byte
         st_next = ST_IDLE;
         oe_next = 4'h0;
         busy_next = 1'b0;
         // Only a mode upper nibble of Ah in this select keeps the mode; a short select never has one
         cont_next = keep_reg;
      end else if (cs_start) begin
         busy_next = 1'b1;
         cnt_next = 6'h00;
         sh_next = 32'h0;
         keep_next = 1'b0;
         bit_next = 3'h0;
         // Continuous mode skips the opcode
         if (cont_reg) begin
            st_next = ST_ADDR;
            dio_next = 1'b1;
            w_next = SFMR_W2;
         end else begin
            st_next = ST_OPC;
         end
      end else begin
         case (st_reg)
            ST_OPC: begin
               if (rise) begin
                  sh_next = {sh_reg[30:0], DQ_I[0]};
                  cnt_next = cnt_reg + 6'h01;
                  if (cnt_reg == OPC_BITS - 6'h01) begin
                     st_next = ST_ADDR;
                     cnt_next = 6'h00;
                     dio_next = 1'b0;
                     alen_next = EXT_ADDR ? 6'd32 : 6'd24;
                     case ({sh_reg[6:0], DQ_I[0]})
                        OP_LAT_READ: w_next = SFMR_W1;
                        OP_LAT_READ_WIDE: begin
                           w_next = SFMR_W1;
                           alen_next = 6'd32;
                        end
                        OP_TWO_OUT: w_next = SFMR_W2;
                        OP_TWO_OUT_WIDE: begin
                           w_next = SFMR_W2;
                           alen_next = 6'd32;
                        end
                        OP_FOUR_OUT, OP_FOUR_OUT_WIDE: begin
                           w_next = SFMR_W4;
                           if (sh_reg[0] != 1'b1 && !DQ_I[0]) alen_next = 6'd32;
                           if (!CFG_ONE[CFG_QUAD_BIT]) st_next = ST_IGNORE;
                        end
                        OP_TWO_IO: begin
                           w_next = SFMR_W2;
                           dio_next = 1'b1;
                        end
                        OP_TWO_IO_WIDE: begin
                           w_next = SFMR_W2;
                           dio_next = 1'b1;
                           alen_next = 6'd32;
                        end
                        default: st_next = ST_IGNORE;
                     endcase
                     if ({sh_reg[6:0], DQ_I[0]} == OP_FOUR_OUT_WIDE) alen_next = 6'd32;
                  end
               end
            end
            ST_ADDR: begin
               if (rise) begin
                  // Two bits per edge for dual I/O, one bit otherwise
                  sh_next = dio_reg ? {sh_reg[29:0], DQ_I[1:0]} : {sh_reg[30:0], DQ_I[0]};
                  cnt_next = cnt_reg + 6'h01;
                  if (cnt_reg == abits - 6'h01) begin
                     cnt_next = 6'h00;
                     st_next = dio_reg ? ST_MODE : ST_DUMMY;
                     dum_next = lat;
                  end
               end
            end
            ST_MODE: begin
               if (rise) begin
                  byte_next = {byte_reg[5:0], DQ_I[1:0]};
                  cnt_next = cnt_reg + 6'h01;
                  // Upper nibble is complete after the second mode cycle
                  if (cnt_reg == 6'h01) begin
                     // Mode state itself changes only when select rises
                     keep_next = ({byte_reg[1:0], DQ_I[1:0]} == MODE_CONT_NIB);
                  end
                  if (cnt_reg == MODE_CYC_TWO - 6'h01) begin
                     st_next = ST_DUMMY;
                     addr_next = new_addr;
                  end
               end
            end
            ST_DUMMY: begin
               if (st_reg == ST_DUMMY && !dio_reg && addr_reg != new_addr && dum_reg == lat) begin
                  addr_next = new_addr;
               end
               // Falls count dummies; with none left the very next fall carries data
               if (dum_reg == DUMMY_NONE) begin
                  st_next = ST_DATA;
                  bit_next = 3'h0;
               end else if (fall) begin
                  dum_next = dum_reg - 4'h1;
                  oe_next = 4'h0;
               end
            end
            ST_DATA: begin
               if (fall) begin
                  cnt_next = cnt_reg + 6'h01;
                  case (w_reg)
                     SFMR_W1: begin
                        dq_next = {2'h0, rd_data[3'h7 - bit_reg], 1'b0};
                        oe_next = 4'h2;
                        bit_next = bit_reg + 3'h1;
                        if (bit_reg == 3'h7) addr_next = addr_reg + 24'h1;
                     end
                     SFMR_W2: begin
                        dq_next = {2'h0, rd_data[3'h7 - bit_reg], rd_data[3'h6 - bit_reg]};
                        oe_next = 4'h3;
                        bit_next = bit_reg + 3'h2;
                        if (bit_reg == 3'h6) addr_next = addr_reg + 24'h1;
                     end
                     default: begin
                        dq_next = (bit_reg == 3'h0) ? rd_data[7:4] : rd_data[3:0];
                        oe_next = 4'hf;
                        bit_next = bit_reg + 3'h4;
                        if (bit_reg == 3'h4) addr_next = addr_reg + 24'h1;
                     end
                  endcase
               end
            end
            default: begin
               oe_next = 4'h0;
            end
         endcase
         if (st_reg == ST_ADDR && rise && cnt_reg == abits - 6'h01 && !dio_reg) begin
            addr_next = {sh_reg[ADDR_W-2:0], DQ_I[0]};
         end
         if (rise && st_reg != ST_DATA && cnt_reg != 6'h3f && st_reg == ST_IGNORE) begin
            cnt_next = cnt_reg + 6'h01;
         end
      end
   end

   // Sequencer registers; reset leaves continuous mode off
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         st_reg <= ST_IDLE;
         sh_reg <= 32'h0;
         cnt_reg <= 6'h00;
         alen_reg <= 6'd24;
         dum_reg <= DUMMY_NONE;
         w_reg <= SFMR_W1;
         dio_reg <= 1'b0;
         cont_reg <= 1'b0;
         keep_reg <= 1'b0;
         addr_reg <= ADDR_ZERO;
         byte_reg <= 8'h00;
         bit_reg <= 3'h0;
         dq_reg <= 4'h0;
         oe_reg <= 4'h0;
         busy_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         sh_reg <= sh_next;
         cnt_reg <= cnt_next;
         alen_reg <= alen_next;
         dum_reg <= dum_next;
         w_reg <= w_next;
         dio_reg <= dio_next;
         cont_reg <= cont_next;
         keep_reg <= keep_next;
         addr_reg <= addr_next;
         byte_reg <= byte_next;
         bit_reg <= bit_next;
         dq_reg <= dq_next;
         oe_reg <= oe_next;
         busy_reg <= busy_next;
      end
   end

   // Outputs straight from flip-flops
   assign DQ_O = dq_reg;
   assign DQ_OE = oe_reg;
   assign CONT_MODE = cont_reg;
   assign BUSY = busy_reg;
endmodule

// file: sfmr_pkg.sv
package sfmr_pkg;
   // Read opcodes
   localparam logic [7:0] OP_LAT_READ = 8'h0b;
   localparam logic [7:0] OP_LAT_READ_WIDE = 8'h0c;
   localparam logic [7:0] OP_TWO_OUT = 8'h3b;
   localparam logic [7:0] OP_TWO_OUT_WIDE = 8'h3c;
   localparam logic [7:0] OP_FOUR_OUT = 8'h6b;
   localparam logic [7:0] OP_FOUR_OUT_WIDE = 8'h6c;
   localparam logic [7:0] OP_TWO_IO = 8'hbb;
   localparam logic [7:0] OP_TWO_IO_WIDE = 8'hbc;
   // Continuous mode upper nibble
   localparam logic [3:0] MODE_CONT_NIB = 4'ha;
   // Array geometry: 24 address bits
   localparam int ADDR_W = 24;
   localparam logic [23:0] ADDR_ZERO = 24'h000000;
   // Dummy cycle counts
   localparam logic [3:0] DUMMY_LONG = 4'h8;
   localparam logic [3:0] DUMMY_NONE = 4'h0;
   // Latency code that selects zero dummy cycles
   localparam logic [1:0] LC_NO_DUMMY = 2'h3;
   // Configuration bit positions
   localparam int CFG_QUAD_BIT = 1;
   localparam int CFG_LC_LSB = 6;
   // Cycle counts for header phases
   localparam logic [5:0] OPC_BITS = 6'h08;
   localparam logic [5:0] MODE_CYC_TWO = 6'h04;
   localparam logic [5:0] SHORT_CS_CYC = 6'h08;
   // Lane selection
   typedef enum logic [1:0] {SFMR_W1, SFMR_W2, SFMR_W4} sfmr_width_e;
endpackage

// file: sfmr_edge.sv
`timescale 1ns/1ns
// Serial clock edge and chip select edge detection; inputs are synchronous.
module sfmr_edge (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins
   input wire logic sck,
   input wire logic cs_n,
   // Events
   output logic rise,
   output logic fall,
   output logic cs_start,
   output logic cs_end
);
   logic sck_reg, sck_next, cs_reg, cs_next;

   // Previous levels
   always_comb begin
      sck_next = sck;
      cs_next = cs_n;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sck_reg <= 1'b0;
         cs_reg <= 1'b1;
      end else begin
         sck_reg <= sck_next;
         cs_reg <= cs_next;
      end
   end

   // Edges count only while selected
   assign rise = sck & ~sck_reg & ~cs_n;
   assign fall = ~sck & sck_reg & ~cs_n;
   assign cs_start = ~cs_n & cs_reg;
   assign cs_end = cs_n & ~cs_reg;
endmodule

// file: sfmr_array.sv
`timescale 1ns/1ns
// Flash array read port, one byte per address, with a load path for tests.
module sfmr_array #(
   parameter int AW = 8
) (
   // Clock
   input wire logic clk,
   // Read
   input wire logic [AW-1:0] rd_addr,
   output logic [7:0] rd_data,
   // Load
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [7:0] wr_data
);
   logic [7:0] mem [0:(1<<AW)-1];

   initial begin
      if (AW < 1 || AW > 24) $error("sfmr_array: AW out of range");
   end

   // Load port stands in for program logic outside this block
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Asynchronous read keeps the first data byte ready at the turnaround edge
   assign rd_data = mem[rd_addr];
endmodule

// file: sfmr_read_ctl_monitor.sv
`timescale 1ns/1ns
// Port-level timing checks on the serial read front end
module sfmr_read_ctl_monitor
   import sfmr_pkg::*;
#(
   parameter int ARRAY_AW = 8
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Serial pins
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic [3:0] DQ_O,
   input wire logic [3:0] DQ_OE,
   // Configuration and status
   input wire logic [7:0] CFG_ONE,
   input wire logic CONT_MODE,
   input wire logic BUSY
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Deselected long enough for the clearing delay to pass
   sequence desel_s;
      CS_N [*4];
   endsequence
   // Serial clock held high while selected: no launch edge in sight
   sequence high_hold_s;
      !CS_N && SCK ##1 !CS_N && SCK;
   endsequence
   reset_clear_a: assert property ($rose(RST_N) |-> DQ_OE == 4'h0 && !CONT_MODE && !BUSY)
      else $error("outputs not clear after reset");
   desel_quiet_a: assert property (desel_s |-> DQ_OE == 4'h0 && !BUSY)
      else $error("lanes driven while deselected");
   lane_set_a: assert property (DQ_OE inside {4'h0, 4'h2, 4'h3, 4'hf})
      else $error("illegal lane enable pattern");
   quad_gate_a: assert property (DQ_OE == 4'hf |-> CFG_ONE[CFG_QUAD_BIT])
      else $error("four lanes driven without quad enable");
   fall_launch_a: assert property ($rose(|DQ_OE) |-> !SCK && $past(SCK, 3))
      else $error("data not launched by a serial clock fall");
   stands_a: assert property (high_hold_s |-> $stable(DQ_O) && $stable(DQ_OE))
      else $error("lanes changed while serial clock high");
   mode_exit_a: assert property ($fell(CONT_MODE) |-> CS_N)
      else $error("continuous mode left while selected");
   busy_on_a: assert property ($fell(CS_N) |-> ##[1:3] BUSY)
      else $error("select not taken");
endmodule

bind sfmr_read_ctl sfmr_read_ctl_monitor #(.ARRAY_AW(ARRAY_AW)) mon_u (
   .CLK(CLK),
   .RST_N(RST_N),
   .SCK(SCK),
   .CS_N(CS_N),
   .DQ_O(DQ_O),
   .DQ_OE(DQ_OE),
   .CFG_ONE(CFG_ONE),
   .CONT_MODE(CONT_MODE),
   .BUSY(BUSY)
);

// file: sfmr_host.sv
`timescale 1ns/1ns
// Host controller model; SCK half period is three CLK, well under the CLK/4 limit
module sfmr_host (
   // Clock
   input wire logic clk,
   // Serial pins
   output logic sck,
   output logic cs_n,
   output logic [3:0] dq_i,
   input wire logic [3:0] dq_o,
   input wire logic [3:0] dq_oe,
   // Byte report
   output logic got,
   output logic [7:0] got_val,
   output logic any_oe
);
   logic [3:0] cap;
   // Idle pins: clock low, deselected
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      dq_i = 4'h0;
      got = 1'b0;
      got_val = 8'h00;
      any_oe = 1'b0;
   end
   // One serial cycle: lanes change with the fall, output read just before the rise
   task automatic tick(input logic [3:0] d);
      sck <= 1'b0;
      dq_i <= d;
      repeat (3) @(posedge clk);
      cap = dq_o;
      any_oe <= any_oe | (|dq_oe);
      sck <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   // One framed read; released lanes toggle so stale values never pass for data
   task automatic run(input logic hop, input logic [7:0] op, input logic [31:0] a,
      input int ab, input int ap, input logic mon, input logic [7:0] md, input int dum,
      input int ln, input int nb);
      logic [7:0] b;
      int i;
      b = 8'h00;
      any_oe <= 1'b0;
      cs_n <= 1'b0;
      if (hop) for (i = 7; i >= 0; i--) tick({3'h0, op[i]});
      for (i = ab - ap; i >= 0; i -= ap) tick(ap == 2 ? {2'h0, a[i+1], a[i]} : {3'h0, a[i]});
      if (mon) for (i = 6; i >= 0; i -= 2) tick({2'h0, md[i+1], md[i]});
      for (i = 0; i < dum + nb * 8 / ln; i++) begin
         tick(~dq_i);
         if (i >= dum) begin
            b = (ln == 4) ? {b[3:0], cap} : (ln == 2) ? {b[5:0], cap[1:0]} : {b[6:0], cap[1]};
            if ((i - dum + 1) % (8 / ln) == 0) begin
               got_val <= b;
               got <= 1'b1;
               @(posedge clk);
               got <= 1'b0;
            end
         end
      end
      cs_n <= 1'b1;
      @(posedge clk);
      sck <= 1'b0;
      dq_i <= ~dq_i;
      repeat (6) @(posedge clk);
   endtask
endmodule

// file: sfmr_read_ctl_tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the read front end
module sfmr_read_ctl_tb_top;
   import sfmr_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ext = 1'b0;
   logic [7:0] cfg = 8'h00;
   logic ld = 1'b0;
   logic [7:0] ld_a = 8'h00;
   logic [7:0] ld_d = 8'h00;
   logic sck, cs_n, got, any_oe, cont, busy;
   logic [3:0] dq_i, dq_o, dq_oe;
   logic [7:0] got_val;
   logic [7:0] mem [256];
   logic [7:0] exp_q [$];
   int err_total = 0;
   int samples_checked = 0;
   int seed = 88135;
   int cyc = 0;
   // 20 MHz clock
   initial begin
      forever #25 clk = ~clk;
   end
   sfmr_read_ctl #(.ARRAY_AW(8)) dut_u (
      .CLK(clk),
      .RST_N(rst_n),
      .SCK(sck),
      .CS_N(cs_n),
      .DQ_I(dq_i),
      .DQ_O(dq_o),
      .DQ_OE(dq_oe),
      .EXT_ADDR(ext),
      .CFG_ONE(cfg),
      .LOAD_EN(ld),
      .LOAD_ADDR(ld_a),
      .LOAD_DATA(ld_d),
      .CONT_MODE(cont),
      .BUSY(busy)
   );
   sfmr_host host_u (
      .clk(clk),
      .sck(sck),
      .cs_n(cs_n),
      .dq_i(dq_i),
      .dq_o(dq_o),
      .dq_oe(dq_oe),
      .got(got),
      .got_val(got_val),
      .any_oe(any_oe)
   );
   // Compare and count
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Counts, verdict and end
   task automatic complete_run();
      $display("Compared %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Each byte the host assembles is matched against the oldest note
   always @(posedge clk) begin
      if (got) check("read byte", got_val, exp_q.size() ? exp_q.pop_front() : 8'hxx);
   end
   // Hang guard, several times the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         complete_run();
      end
   end
   // One frame: random start, OP_LAT_READ_WIDE reads start at FEh, one below the array top, to wrap
   task automatic rd(input logic hop, input logic [7:0] op, input int ab, input int ap,
      input logic [7:0] md, input logic [7:0] c, input logic e, input int ln, input int nb);
      logic [31:0] a;
      int i;
      a = $random(seed);
      if (op == OP_LAT_READ_WIDE) a[7:0] = 8'hfe;
      cfg <= c;
      ext <= e;
      @(posedge clk);
      for (i = 0; i < nb; i++) exp_q.push_back(mem[8'(a[7:0] + i)]);
      host_u.run(hop, op, a, ab, ap, md != 8'h00, md, (c[7:6] == 2'h3) ? 0 : 8, ln, nb);
      $display("Frame done, opcode %h", op);
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'($random(seed));
         ld <= 1'b1;
         ld_a <= 8'(i);
         ld_d <= mem[i];
         @(posedge clk);
      end
      ld <= 1'b0;
      @(posedge clk);
      check("mode after reset", {7'h00, cont}, 8'h00);
      rd(1, OP_LAT_READ, 24, 1, 8'h00, 8'hc0, 0, 1, 2);
      rd(1, OP_LAT_READ_WIDE, 32, 1, 8'h00, 8'h00, 0, 1, 3);
      rd(1, OP_LAT_READ, 32, 1, 8'h00, 8'hc0, 1, 1, 1);
      rd(1, OP_TWO_OUT, 32, 1, 8'h00, 8'h80, 1, 2, 2);
      rd(1, OP_TWO_OUT_WIDE, 32, 1, 8'h00, 8'hc0, 0, 2, 2);
      rd(1, OP_FOUR_OUT, 24, 1, 8'h00, 8'h42, 0, 4, 2);
      rd(1, OP_FOUR_OUT_WIDE, 32, 1, 8'h00, 8'hc2, 0, 4, 2);
      rd(1, OP_FOUR_OUT, 24, 1, 8'h00, 8'h00, 0, 1, 0);
      check("quad refused", {7'h00, any_oe}, 8'h00);
      rd(1, OP_TWO_IO, 24, 2, 8'ha5, 8'h00, 0, 2, 2);
      check("mode entered", {7'h00, cont}, 8'h01);
      rd(0, 8'h00, 24, 2, 8'h3a, 8'hc0, 0, 2, 2);
      check("mode left", {7'h00, cont}, 8'h00);
      rd(1, OP_TWO_IO_WIDE, 32, 2, 8'hac, 8'hc0, 0, 2, 1);
      rd(0, 8'h00, 0, 2, 8'h00, 8'h00, 0, 1, 0);
      check("short select", {7'h00, cont}, 8'h00);
      check("notes left", 8'(exp_q.size()), 8'h00);
      complete_run();
   end
endmodule
